//--- logic/status_bank_pkg.sv
// Constants, field layouts and carrier types for the SPI status flag bank.
// Assumes one 125 MHz system clock; frames arrive on slow asynchronous pins.
// Notes on behaviour
// - Frame is 32 bits: address, mode, data, CRC.
// - Status word occupies frame bits 8 to 23.
// - Mode bit 0 reads word, flags unchanged.
// - Mode bit 1 clears whole clearable word.
// - Clear ignores the payload in bits 8-23.
// - Flags stay set until explicitly cleared.
// - Reserved bits 14:13 read zero, never cleared.
// - Bit 15 flags a power-on reset.
// - Bit 12 latches charge pump overtemperature.
// - Bit 11 latches fourth-undervoltage fail-safe entry.
// - Bits 10, 9 latch switch supply low/high.
// - Bit 6 battery low, only while regulator enabled.
// - Bit 5 battery high, only while regulator enabled.
// - Bits 4-0 latch pump and main regulator faults.
// - Power-on sets bit 15; soft reset clears it.
`default_nettype none
package status_bank_pkg;

  localparam int FRAME_BITS = 32;
  localparam int ADDR_BITS  = 7;
  localparam int WORD_BITS  = 16;
  localparam int NUM_REGS   = 20;
  localparam int MODE_BIT   = 7;
  localparam int DATA_LSB   = 8;
  localparam int DATA_MSB   = 23;
  localparam int SUP_IDX    = 0;
  localparam int BATT_LOW_BIT  = 6;
  localparam int BATT_HIGH_BIT = 5;

  localparam logic [15:0] SUP_POR_RESET  = 16'h8000;
  localparam logic [15:0] SUP_SOFT_RESET = 16'h0000;
  localparam logic [15:0] SUP_CLEAR_MASK = 16'h9fff;
  localparam logic [7:0]  CRC_FILL       = 8'h00;
  localparam logic [7:0]  HEAD_FILL      = 8'h00;
  localparam logic [19:0] REG_CLEARABLE  = 20'h7ffff;

  localparam logic [6:0] REG_ADDR [NUM_REGS] = '{
    7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46,
    7'h50, 7'h51, 7'h52, 7'h53, 7'h54, 7'h55,
    7'h57, 7'h58, 7'h59, 7'h60, 7'h61, 7'h63, 7'h70};

  typedef logic [15:0] word_t;

  typedef struct packed {
    logic pump_overtemp_flag;
    logic main_reg_uv_failsafe_flag;
    logic switch_supply_low_flag;
    logic switch_supply_high_flag;
    logic internal_supply_low_flag;
    logic internal_supply_high_flag;
    logic battery_low_flag;
    logic battery_high_flag;
    logic pump_low_flag;
    logic main_reg_short_flag;
    logic main_reg_low_flag;
    logic main_reg_high_flag;
    logic main_reg_prewarn_flag;
  } supply_ev_s;

  typedef struct packed {
    logic [7:0]  crc;
    logic [15:0] data;
    logic        mode;
    logic [6:0]  addr;
  } frame_s;

  function automatic logic [4:0] reg_index(input logic [6:0] a);
    logic [4:0] r;
    r = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_ADDR[i] == a) r = 5'(i);
    end
    return r;
  endfunction

  function automatic logic reg_mapped(input logic [6:0] a);
    logic m;
    m = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_ADDR[i] == a) m = 1'b1;
    end
    return m;
  endfunction

endpackage
`default_nettype wire

//--- logic/pin_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes each bit is an independent level; no word coherency.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int                WIDTH     = 1,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stage_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q  <= RESET_VAL;
      stage_q <= RESET_VAL;
    end else begin
      meta_q  <= i_d;
      stage_q <= meta_q;
    end
  end

  assign o_q = stage_q;
endmodule // pin_sync
`default_nettype wire

//--- logic/sticky_word.sv
// One word of sticky flags: set by events, cleared as a whole word.
// Assumes set and clear come from the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module sticky_word #(
  parameter int               WIDTH      = 16,
  parameter logic [WIDTH-1:0] POR_VAL    = '0,
  parameter logic [WIDTH-1:0] SOFT_VAL   = '0,
  parameter logic [WIDTH-1:0] CLEAR_MASK = '1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_soft_rst,
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic             i_clear,
  output logic      [WIDTH-1:0] o_word
);
  logic [WIDTH-1:0] word_q;
  logic [WIDTH-1:0] word_d;

  always_comb begin
    word_d = word_q;
    if (i_soft_rst) begin
      word_d = SOFT_VAL;
    end else begin
      if (i_clear) word_d = word_q & ~CLEAR_MASK;
      word_d = (word_d | i_set) & CLEAR_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) word_q <= POR_VAL;
    else          word_q <= word_d;
  end

  assign o_word = word_q;
endmodule // sticky_word
`default_nettype wire

//--- logic/spi_status_flag_bank.sv
// SPI slave front end and status register bank.
// Assumes SPI mode 0, LSB of the frame first, and an SPI clock
// at most one eighth of i_clk so oversampling sees every edge.
`timescale 1ns/10ps
`default_nettype none
module spi_status_flag_bank #(
  parameter int FRAME_LEN = status_bank_pkg::FRAME_BITS,
  parameter int WORD_LEN  = status_bank_pkg::WORD_BITS
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_soft_rst,
  input  wire logic                        i_sclk,
  input  wire logic                        i_cs_n,
  input  wire logic                        i_mosi,
  input  wire status_bank_pkg::supply_ev_s i_supply_ev,
  input  wire logic                        i_main_reg_en,
  input  wire logic [19:0][15:0]           i_ext_words,
  output logic                             o_miso,
  output logic                             o_miso_oe,
  output logic [19:0]                      o_clear_strobe,
  output logic [15:0]                      o_supply_word
);

  if (FRAME_LEN != 32 || WORD_LEN != 16) begin : g_bad_size
    $error("Frame must be 32 bits and word 16 bits");
  end

  typedef enum logic {ST_IDLE, ST_ACTIVE} frame_state_e;

  localparam int SYNC_W = 3 + $bits(status_bank_pkg::supply_ev_s) + 1;
  // Chip select idles high so reset does not look like a frame start
  localparam logic [SYNC_W-1:0] SYNC_RST = {1'b0, 1'b1, {(SYNC_W-2){1'b0}}};

  logic [SYNC_W-1:0]           sync_bus;
  logic                        sclk_s;
  logic                        cs_n_s;
  logic                        mosi_s;
  status_bank_pkg::supply_ev_s ev_s;
  logic                        reg_en_s;

  pin_sync #(
    .WIDTH     (SYNC_W),
    .RESET_VAL (SYNC_RST)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_sclk, i_cs_n, i_mosi, i_supply_ev, i_main_reg_en}),
    .o_q     (sync_bus)
  );

  assign {sclk_s, cs_n_s, mosi_s, ev_s, reg_en_s} = sync_bus;

  // Edge detection on synchronised pins

  logic sclk_prev_q;
  logic cs_prev_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_n_s;
    end
  end

  always_comb begin
    sclk_rise = sclk_s & ~sclk_prev_q;
    sclk_fall = ~sclk_s & sclk_prev_q;
    cs_fall   = cs_prev_q & ~cs_n_s;
    cs_rise   = ~cs_prev_q & cs_n_s;
  end

  // Supply-fail word

  logic [15:0] sup_set;
  logic [15:0] sup_word;

  always_comb begin
    sup_set = {3'b000, ev_s};
    // Battery detectors are meaningless with the regulator off
    sup_set[status_bank_pkg::BATT_LOW_BIT] =
      ev_s.battery_low_flag & reg_en_s;
    sup_set[status_bank_pkg::BATT_HIGH_BIT] =
      ev_s.battery_high_flag & reg_en_s;
  end

  logic [19:0] clr_q;
  logic [19:0] clr_d;

  sticky_word #(
    .WIDTH      (16),
    .POR_VAL    (status_bank_pkg::SUP_POR_RESET),
    .SOFT_VAL   (status_bank_pkg::SUP_SOFT_RESET),
    .CLEAR_MASK (status_bank_pkg::SUP_CLEAR_MASK)
  ) u_supply_word (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_soft_rst (i_soft_rst),
    .i_set      (sup_set),
    .i_clear    (clr_q[status_bank_pkg::SUP_IDX]),
    .o_word     (sup_word)
  );

  // Frame engine

  frame_state_e            state_q;
  frame_state_e            state_d;
  logic [5:0]              cnt_q;
  logic [5:0]              cnt_d;
  status_bank_pkg::frame_s rx_q;
  status_bank_pkg::frame_s rx_d;
  logic [31:0]             tx_q;
  logic [31:0]             tx_d;
  logic                    miso_q;
  logic                    miso_d;
  logic                    oe_q;
  logic                    oe_d;
  logic [15:0]             sup_q;
  logic [4:0]              rd_idx;
  logic                    rd_hit;
  logic [15:0]             rd_word;

  always_comb begin
    rd_idx  = status_bank_pkg::reg_index(rx_q.addr);
    rd_hit  = status_bank_pkg::reg_mapped(rx_q.addr);
    rd_word = 16'h0000;
    if (rd_hit) begin
      if (rd_idx == 5'(status_bank_pkg::SUP_IDX)) rd_word = sup_word;
      else                                        rd_word = i_ext_words[rd_idx];
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    miso_d  = miso_q;
    oe_d    = oe_q;
    clr_d   = '0;
    case (state_q)
      ST_IDLE: begin
        if (cs_fall) begin
          state_d = ST_ACTIVE;
          cnt_d   = 6'h00;
          tx_d    = {status_bank_pkg::CRC_FILL, 16'h0000, status_bank_pkg::HEAD_FILL};
          miso_d  = status_bank_pkg::HEAD_FILL[0];
          oe_d    = 1'b1;
        end
      end
      ST_ACTIVE: begin
        if (cs_rise) begin
          state_d = ST_IDLE;
          oe_d    = 1'b0;
          miso_d  = 1'b0;
          // Short or long frames are dropped without effect
          if (cnt_q == 6'(FRAME_LEN) && rx_q.mode && rd_hit) begin
            clr_d[rd_idx] = status_bank_pkg::REG_CLEARABLE[rd_idx];
          end
        end else begin
          if (sclk_rise && cnt_q != 6'h3f) begin
            cnt_d = cnt_q + 6'h01;
            if (cnt_q < 6'(FRAME_LEN)) rx_d[cnt_q[4:0]] = mosi_s;
            // Address is complete once the mode bit arrives
            if (cnt_q == 6'(status_bank_pkg::MODE_BIT)) begin
              tx_d[status_bank_pkg::DATA_MSB:status_bank_pkg::DATA_LSB] = rd_word;
            end
          end
          if (sclk_fall) begin
            miso_d = (cnt_q < 6'(FRAME_LEN)) ? tx_q[cnt_q[4:0]] : 1'b0;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        oe_d    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= 6'h00;
      rx_q    <= '0;
      tx_q    <= 32'h0000_0000;
      miso_q  <= 1'b0;
      oe_q    <= 1'b0;
      clr_q   <= 20'h00000;
      sup_q   <= status_bank_pkg::SUP_POR_RESET;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      miso_q  <= miso_d;
      oe_q    <= oe_d;
      clr_q   <= clr_d;
      sup_q   <= sup_word;
    end
  end

  assign o_miso         = miso_q;
  assign o_miso_oe      = oe_q;
  assign o_clear_strobe = clr_q;
  assign o_supply_word  = sup_q;

  // Checks

  frame_len_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (|clr_q) |-> $past(cnt_q) == 6'd32)
    else $error("Clear issued for a frame not 32 bits long");

  clear_mode_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (|clr_q) |-> $past(rx_q.mode))
    else $error("Clear issued by a read frame");

  data_lane_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_q == ST_ACTIVE && !cs_rise && sclk_rise && cnt_q == 6'd7)
    |=> tx_q[23:8] == $past(rd_word))
    else $error("Status word not placed in frame bits 8 to 23");

  clear_all_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (clr_q[0] && sup_set == 16'h0000 && !i_soft_rst)
    |=> sup_word == 16'h0000)
    else $error("Clear left flags set");

  flags_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (($past(sup_word) & ~sup_word) != 16'h0000)
    |-> $past(clr_q[0] || i_soft_rst))
    else $error("Flag dropped without clear");

  reserved_zero_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    sup_word[14:13] == 2'b00)
    else $error("Reserved supply bits not zero");

  overtemp_latch_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (ev_s.pump_overtemp_flag && !i_soft_rst) |=> sup_word[12])
    else $error("Pump overtemperature not latched");

  battery_qual_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(sup_word[6]) |-> $past(ev_s.battery_low_flag && reg_en_s))
    else $error("Battery low latched while regulator off");

  set_wins_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (clr_q[0] && !i_soft_rst)
    |=> (sup_word & $past(sup_set)) == $past(sup_set))
    else $error("Event lost to a simultaneous clear");

  soft_por_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_soft_rst |=> !sup_word[15])
    else $error("Soft reset left power-on flag set");

  ident_noclear_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !clr_q[19])
    else $error("Clear strobe issued for the identification word");

  read_keeps_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_q == ST_ACTIVE && cs_rise && !rx_q.mode) |=> clr_q == 20'h00000)
    else $error("Read frame issued a clear strobe");

  short_frame_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_q == ST_ACTIVE && cs_rise && cnt_q != 6'd32) |=> clr_q == 20'h00000)
    else $error("Frame of wrong length issued a clear strobe");

  clear_payload_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_q == ST_ACTIVE && cs_rise && cnt_q == 6'd32 && rx_q.mode && rd_hit && rd_idx != 5'd19) |=> clr_q[$past(rd_idx)])
    else $error("Valid clear frame gave no strobe");

  strobe_pulse_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (|clr_q) |=> clr_q == 20'h00000)
    else $error("Clear strobe longer than one cycle");

  head_zero_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_q == ST_ACTIVE && cnt_q <= 6'd7) |-> !miso_q)
    else $error("Head byte of answer not zero");

  crc_zero_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_q == ST_ACTIVE && !cs_rise && sclk_fall && cnt_q >= 6'd24) |=> !miso_q)
    else $error("Trailing byte of answer not zero");

  miso_idle_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_q == ST_IDLE) |-> !miso_q && !oe_q)
    else $error("Data out driven outside a frame");

  por_only_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !$rose(sup_word[15]))
    else $error("Power-on flag set without a power-on reset");

  failsafe_latch_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (ev_s.main_reg_uv_failsafe_flag && !i_soft_rst) |=> sup_word[11])
    else $error("Fail-safe entry not latched");

  switch_low_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (ev_s.switch_supply_low_flag && !i_soft_rst) |=> sup_word[10])
    else $error("Switch supply low not latched");

  switch_high_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (ev_s.switch_supply_high_flag && !i_soft_rst) |=> sup_word[9])
    else $error("Switch supply high not latched");

  supply_low_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (ev_s.internal_supply_low_flag && !i_soft_rst) |=> sup_word[8])
    else $error("Internal supply low not latched");

  batt_low_latch_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (ev_s.battery_low_flag && reg_en_s && !i_soft_rst) |=> sup_word[6])
    else $error("Battery low not latched with regulator on");

  batt_high_qual_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(sup_word[5]) |-> $past(ev_s.battery_high_flag && reg_en_s))
    else $error("Battery high latched while regulator off");

  reg_faults_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_soft_rst |=> (sup_word[4:0] & $past(sup_set[4:0])) == $past(sup_set[4:0]))
    else $error("Pump or regulator fault not latched");

  soft_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_soft_rst |=> sup_word == 16'h0000)
    else $error("Soft reset left supply flags set");

endmodule // spi_status_flag_bank
`default_nettype wire

//--- dv/spi_host_model.sv
// Host-side SPI master: mode 0, frame LSB first, one frame per xfer call.
// Assumes i_clk is the system clock; sclk half period is HALF system clocks.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model #(
  parameter int HALF = 8
) (
  input  wire logic i_clk,
  input  wire logic i_miso,
  input  wire logic i_miso_oe,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // Fewer than 32 bits makes an aborted frame
  task automatic xfer(input logic [31:0] tx, input int nb, output logic [31:0] rx);
    rx = '0;
    o_cs_n <= 1'b0;
    for (int n = 0; n < nb; n++) begin
      o_mosi <= tx[n];
      repeat (HALF) @(posedge i_clk);
      // Undriven line must never pass as data
      rx[n] = i_miso_oe ? i_miso : 1'bx;
      o_sclk <= 1'b1;
      repeat (HALF) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge i_clk);
    o_cs_n <= 1'b1;
    // Released data line shows the inverse, not a stale bit
    o_mosi <= ~o_mosi;
    repeat (HALF) @(posedge i_clk);
  endtask
endmodule  // spi_host_model
`default_nettype wire

//--- dv/spi_status_flag_bank_tb.sv
// Self-checking bench for the SPI status flag bank via the host model.
// Assumes the package, design and host model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module spi_status_flag_bank_tb;
  logic                        i_clk;
  logic                        i_rst_n;
  logic                        i_soft_rst;
  logic                        i_main_reg_en;
  status_bank_pkg::supply_ev_s i_supply_ev;
  logic [19:0][15:0]           ext;
  logic                        sclk, cs_n, mosi, miso, miso_oe;
  logic [19:0]                 strobe;
  logic [15:0]                 word;
  logic [19:0]                 stb_acc;
  logic [31:0]                 rx;
  int                          stb_cnt = 0;
  int                          err_count = 0;
  int                          checks = 0;
  int                          cyc = 0;

  spi_status_flag_bank spi_status_flag_bank_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_soft_rst(i_soft_rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_mosi(mosi), .i_supply_ev(i_supply_ev), .i_main_reg_en(i_main_reg_en), .i_ext_words(ext),
    .o_miso(miso), .o_miso_oe(miso_oe), .o_clear_strobe(strobe), .o_supply_word(word));
  spi_host_model spi_host_model_i (
    .i_clk(i_clk), .i_miso(miso), .i_miso_oe(miso_oe), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));

  always #4 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (strobe !== '0) begin
      stb_acc <= stb_acc | strobe;
      stb_cnt <= stb_cnt + 1;
    end
    if (cyc == 60000) begin
      err_count++;
      $display("CHECK FAILED t=%0t timeout", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic note(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s", $time, what);
    end
  endtask
  task automatic chk_word(input logic [15:0] exp);
    note(word === exp, $sformatf("word %h exp %h", word, exp));
  endtask
  task automatic chk_frame(input logic [31:0] exp);
    note(rx === exp, $sformatf("frame %h exp %h", rx, exp));
  endtask
  task automatic chk_strobe(input logic [19:0] exp);
    note(stb_acc === exp && stb_cnt == ((exp != '0) ? 1 : 0), $sformatf("strobe %h exp %h", stb_acc, exp));
  endtask

  task automatic frame(input logic [6:0] a, input logic m, input logic [15:0] d, input int nb);
    status_bank_pkg::frame_s f;
    f = '{crc: status_bank_pkg::CRC_FILL, data: d, mode: m, addr: a};
    stb_acc = '0;
    stb_cnt = 0;
    spi_host_model_i.xfer(f, nb, rx);
    repeat (10) @(posedge i_clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    frame(a, 1'b0, 16'h0000, 32);
    chk_frame({8'h00, exp, 8'h00});
  endtask
  task automatic clr(input logic [6:0] a, input logic [15:0] d);
    frame(a, 1'b1, d, 32);
  endtask
  task automatic pulse_ev(input int b, input logic en);
    i_main_reg_en <= en;
    repeat (4) @(posedge i_clk);
    i_supply_ev <= status_bank_pkg::supply_ev_s'(13'h0001 << b);
    repeat (8) @(posedge i_clk);
    i_supply_ev <= '0;
    repeat (8) @(posedge i_clk);
  endtask
  task automatic do_reset();
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask

  initial begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    i_soft_rst = 1'b0;
    i_main_reg_en = 1'b1;
    i_supply_ev = '0;
    for (int k = 0; k < 20; k++) ext[k] = {3'h5, 5'(k), ~8'(k)};
    do_reset();
    chk_word(16'h8000);
    rd(7'h40, 16'h8000);
    chk_word(16'h8000);
    clr(7'h40, 16'hffff);
    chk_strobe(20'h00001);
    chk_word(16'h0000);
    for (int b = 0; b < 13; b++) begin
      pulse_ev(b, 1'b1);
      chk_word(16'h0001 << b);
      clr(7'h40, 16'hffff >> b);
      chk_word(16'h0000);
    end
    pulse_ev(6, 1'b0);
    pulse_ev(5, 1'b0);
    chk_word(16'h0000);
    i_main_reg_en <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_supply_ev <= '1;
    repeat (8) @(posedge i_clk);
    chk_word(16'h1fff);
    rd(7'h40, 16'h1fff);
    i_supply_ev <= status_bank_pkg::supply_ev_s'(13'h1000);
    clr(7'h40, 16'h0000);
    chk_word(16'h1000);
    i_supply_ev <= '0;
    frame(7'h40, 1'b1, 16'h0000, 31);
    chk_strobe(20'h00000);
    chk_word(16'h1000);
    for (int k = 1; k < 20; k++) begin
      rd(status_bank_pkg::REG_ADDR[k], ext[k]);
      clr(status_bank_pkg::REG_ADDR[k], 16'h5a5a);
      chk_strobe((k == 19) ? 20'h00000 : (20'h00001 << k));
    end
    rd(7'h7f, 16'h0000);
    clr(7'h7f, 16'hffff);
    chk_strobe(20'h00000);
    chk_word(16'h1000);
    i_soft_rst <= 1'b1;
    @(posedge i_clk);
    i_soft_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk_word(16'h0000);
    do_reset();
    chk_word(16'h8000);
    close_out();
  end
endmodule  // spi_status_flag_bank_tb
`default_nettype wire
